// file: rtl/rtcc_pkg.sv
// Constants for the real-time clock block: register offsets, field positions,
// calendar limits and crystal timing figures.
// Assumes a byte-wide special function register port from the processor core.
package rtcc_pkg;
  // Register offsets on the processor register port
  localparam logic [7:0] ADDR_CAL_OUTPUT_CONFIG = 8'h0F;
  localparam logic [7:0] ADDR_RTC_CONFIG = 8'hA1;
  localparam logic [7:0] ADDR_ALARM_CONFIG = 8'hA2;
  localparam logic [7:0] ADDR_NOMINAL_CLOCK_TRIM = 8'hF6;
  localparam logic [7:0] ADDR_TEMPERATURE_CORRECTION = 8'hF7;
  localparam logic [7:0] ADDR_CRYSTAL_TURNOVER_OFFSET = 8'h10;
  localparam logic [7:0] ADDR_CRYSTAL_GAIN_LOW = 8'h11;
  localparam logic [7:0] ADDR_CRYSTAL_GAIN_HIGH = 8'h12;
  localparam logic [7:0] ADDR_SECOND = 8'h02;
  localparam logic [7:0] ADDR_MINUTE = 8'h03;
  localparam logic [7:0] ADDR_HOUR = 8'h04;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h05;
  localparam logic [7:0] ADDR_MONTHDAY = 8'h06;
  localparam logic [7:0] ADDR_MONTH = 8'h07;
  localparam logic [7:0] ADDR_YEAR = 8'h08;
  localparam logic [7:0] ADDR_ALARM_SECOND = 8'h09;
  localparam logic [7:0] ADDR_ALARM_MINUTE = 8'h0A;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0B;
  localparam logic [7:0] ADDR_ALARM_WEEKDAY = 8'h0C;
  localparam logic [7:0] ADDR_ALARM_MONTHDAY = 8'h0D;
  localparam logic [7:0] ADDR_INTERVAL_LIMIT = 8'h0E;

  // Field positions of rtc_config
  localparam int CFG_INTERVAL_MATCH_FLAG = 2;
  localparam int CFG_INTERVAL_ONE_SHOT = 3;
  localparam int CFG_TICK_SOURCE_LO = 4;
  localparam int CFG_TICK_SOURCE_HI = 5;
  localparam int CFG_INTERVAL_RUN_ENABLE = 6;
  // Field positions of alarm_config
  localparam int ALM_MATCH_FLAG = 6;
  localparam int ALM_EN_SECOND = 0;
  localparam int ALM_EN_MONTHDAY = 4;
  // Field positions of cal_output_config and crystal_gain_high
  localparam int CAL_OUTPUT_ENABLE = 6;
  localparam int CAL_RATE_LO = 4;
  localparam int CAL_RATE_HI = 5;
  localparam int CAL_PIN_COUNT = 4;
  localparam int GAIN_AUTO_ENABLE = 7;

  // Calendar limits
  localparam logic [5:0] LAST_SECOND = 6'h3B;
  localparam logic [5:0] LAST_MINUTE = 6'h3B;
  localparam logic [4:0] LAST_HOUR = 5'h17;
  localparam logic [2:0] LAST_WEEKDAY = 3'h6;
  localparam logic [3:0] MONTH_FEB = 4'h2;
  localparam logic [3:0] MONTH_APR = 4'h4;
  localparam logic [3:0] MONTH_JUN = 4'h6;
  localparam logic [3:0] MONTH_SEP = 4'h9;
  localparam logic [3:0] MONTH_NOV = 4'hB;
  localparam logic [3:0] LAST_MONTH = 4'hC;
  localparam logic [6:0] LAST_YEAR = 7'h63;
  localparam logic [4:0] DAYS_SHORT_FEB = 5'h1C;
  localparam logic [4:0] DAYS_LEAP_FEB = 5'h1D;
  localparam logic [4:0] DAYS_SHORT = 5'h1E;
  localparam logic [4:0] DAYS_LONG = 5'h1F;
  localparam logic [4:0] FIRST_DAY = 5'h01;
  localparam logic [3:0] FIRST_MONTH = 4'h1;

  // Crystal timing in crystal pulses
  localparam int XTAL_HZ = 32768;
  localparam int FAST_FACTOR = 125;
  localparam int TICK_128_HZ = 128;
  localparam int PPM_PER_LSB = 2;
  localparam int TRIM_LIMIT_PPM = 248;
  localparam int PPM_SCALE = 1000000;
  localparam int TRIM_WINDOW = PPM_SCALE / PPM_PER_LSB;
  localparam logic signed [8:0] TRIM_LIMIT_LSB = 9'(TRIM_LIMIT_PPM / PPM_PER_LSB);
  localparam logic [15:0] FAST_SECOND = 16'(XTAL_HZ / FAST_FACTOR);
  localparam logic [7:0] DIV_128 = 8'(XTAL_HZ / TICK_128_HZ - 1);
  localparam int GAIN_SHIFT = 15;
  // Half periods of the calibration output per rate setting
  localparam logic [15:0] HALF_1HZ = 16'(XTAL_HZ / 2);
  localparam logic [15:0] HALF_512HZ = 16'(XTAL_HZ / (2 * 512));
  localparam logic [15:0] HALF_500HZ = 16'(XTAL_HZ / (2 * 500));
  localparam logic [15:0] HALF_16KHZ = 16'h0001;
  // Power modes
  localparam logic [1:0] LOWEST_POWER_MODE = 2'h2;
endpackage

// file: rtl/rtcc_top.sv
// Real-time clock: calendar, interval timer, alarm, digital crystal trim,
// temperature trim and calibration pulse output.
// Assumes xtal_tick is a one-cycle pulse per crystal edge, synchronous to mclk.
// Summary of operation
// RL1 - February rolls after 28 days, 29 in leap; Apr/Jun/Sep/Nov 30; others 31.
// RL2 - Year counts that are multiples of four are leap years.
// RL3 - Alarm or interval event sets its flag; request reaches core if enabled.
// RL4 - Interrupt entry leaves flags alone; software clears them by writing zero.
// RL5 - The pending request is exactly the OR of the two event flags.
// RL6 - Wake request persists until the event flags are cleared.
// RL7 - Enabled interval ticks count to the limit, then flag an interval event.
// RL8 - Counter clears and restarts, or is held after the event in one-shot.
// RL9 - Software writes the limit first and waits one 128 Hz period.
// RL10 - Software disables, waits, checks enable clear, then changes tick source.
// RL11 - Only enabled alarm fields are compared; all matching sets the alarm flag.
// RL12 - The alarm flag sits at bit 6 of alarm configuration.
// RL13 - Crystal error is trimmed by inserting or removing crystal pulses.
// RL14 - Trim is nominal plus temperature register, 2 ppm per step, capped 248 ppm.
// RL15 - Calibration pulse appears only when enabled, on selected pins.
// RL16 - Rate select: 1 Hz, 512 Hz, 500 Hz or 16384 Hz; the 500 Hz setting has a half period of 32 pulses and gives 512 Hz here.
// RL17 - Fast settings run timekeeping 125 times faster.
// RL18 - Fast settings are honoured only outside the lowest power mode.
// RL19 - Temperature trim is gain over 2^15 times squared temperature offset.
// RL20 - Gain high bit 7 enables automatic temperature trim; cleared by reset.
// RL21 - Automatic trim makes the temperature correction register read-only.
// RL22 - Each completed temperature reading recomputes the temperature trim.
// RL23 - Date past rollover returns to one, month steps; month twelve steps year.
// RL24 - Interval settings pass into the 128 Hz domain within one period.
module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int SECOND_TICKS = XTAL_HZ,
  parameter int TRIM_WINDOW_TICKS = TRIM_WINDOW
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic xtal_tick,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic clock_irq_enable,
  input wire logic [1:0] power_mode,
  input wire logic [7:0] temperature_reading,
  input wire logic temperature_done,
  output logic clock_irq_pending,
  output logic clock_irq,
  output logic wake_request,
  output logic [CAL_PIN_COUNT-1:0] cal_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] date;
    logic [3:0] month;
    logic [6:0] year;
    logic [15:0] presc;
    logic [7:0] div128;
    logic [18:0] win;
    logic [7:0] trim_left;
    logic trim_add;
    logic ins_pend;
    logic skip_pend;
    logic [7:0] rtc_config;
    logic it_en_s;
    logic [1:0] it_src_s;
    logic it_one_shot_s;
    logic [7:0] it_limit_s;
    logic [7:0] interval_limit;
    logic [7:0] it_cnt;
    logic it_hold;
    logic interval_match_flag;
    logic [4:0] alarm_en;
    logic alarm_match_flag;
    logic alarm_prev;
    logic [5:0] alarm_second_field;
    logic [5:0] alarm_minute_field;
    logic [4:0] alarm_hour_field;
    logic [2:0] alarm_weekday_field;
    logic [4:0] alarm_monthday_field;
    logic [7:0] cal_output_config;
    logic [15:0] cal_div;
    logic cal_lvl;
    logic [7:0] nominal_clock_trim;
    logic [7:0] temperature_correction;
    logic [7:0] crystal_turnover_offset;
    logic [7:0] crystal_gain_low;
    logic [7:0] crystal_gain_high;
    logic [7:0] rdata;
  } rtcc_state_t;

  rtcc_state_t st;
  rtcc_state_t next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Last day of a month, leap-year aware
  function automatic logic [4:0] rtcc_month_days(input logic [3:0] m, input logic [6:0] y);
    if (m == MONTH_FEB) begin
      return (y[1:0] == 2'h0) ? DAYS_LEAP_FEB : DAYS_SHORT_FEB; // RL1 RL2
    end
    if (m == MONTH_APR || m == MONTH_JUN || m == MONTH_SEP || m == MONTH_NOV) begin
      return DAYS_SHORT; // RL1
    end
    return DAYS_LONG;
  endfunction

  // Calibration half period per rate code
  function automatic logic [15:0] rtcc_cal_half(input logic [1:0] rate);
    unique case (rate)
      2'h0: return HALF_1HZ;
      2'h1: return HALF_512HZ;
      2'h2: return HALF_500HZ;
      2'h3: return HALF_16KHZ;
    endcase
  endfunction

  logic fast_mode;
  logic ctick;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;
  logic t128;
  logic src_tick;
  logic alarm_match;
  logic signed [8:0] trim_sum;
  logic signed [8:0] trim_sat;
  logic signed [8:0] temp_diff;
  logic [17:0] temp_sq;
  logic [32:0] temp_prod;
  logic [17:0] temp_corr;
  logic [14:0] gain;
  logic wr_hit;

  // ----------------------------------------------------------------------
  // Combinational datapath
  // ----------------------------------------------------------------------
  // Fast timekeeping only outside the lowest power mode
  assign fast_mode = st.cal_output_config[CAL_RATE_HI] &&
                     (power_mode != LOWEST_POWER_MODE); // RL17 RL18
  // Pulse insertion and removal on the crystal pulse stream
  assign ctick = (xtal_tick && !st.skip_pend) || (!xtal_tick && st.ins_pend); // RL13
  // At or past the end, so a switch into fast mode never waits for a prescaler wrap
  assign sec_tick = ctick && (fast_mode ? (st.presc >= FAST_SECOND - 16'h0001)
                                        : (st.presc >= 16'(SECOND_TICKS - 1))); // RL17
  assign min_tick = sec_tick && (st.sec == LAST_SECOND);
  assign hour_tick = min_tick && (st.min == LAST_MINUTE);
  assign t128 = ctick && (st.div128 == DIV_128);
  always_comb begin
    unique case (st.it_src_s)
      2'h0: src_tick = t128;
      2'h1: src_tick = sec_tick;
      2'h2: src_tick = min_tick;
      2'h3: src_tick = hour_tick;
    endcase
  end
  // Enabled alarm fields only; no field enabled means no match
  assign alarm_match = (st.alarm_en != 5'h00) &&
    (!st.alarm_en[0] || st.sec == st.alarm_second_field) &&
    (!st.alarm_en[1] || st.min == st.alarm_minute_field) &&
    (!st.alarm_en[2] || st.hour == st.alarm_hour_field) &&
    (!st.alarm_en[3] || st.wday == st.alarm_weekday_field) &&
    (!st.alarm_en[ALM_EN_MONTHDAY] || st.date == st.alarm_monthday_field); // RL11
  // Sum of both trims, saturated
  assign trim_sum = $signed({st.nominal_clock_trim[7], st.nominal_clock_trim}) +
                    $signed({st.temperature_correction[7], st.temperature_correction}); // RL14
  assign trim_sat = (trim_sum > TRIM_LIMIT_LSB) ? TRIM_LIMIT_LSB :
                    (trim_sum < -TRIM_LIMIT_LSB) ? -TRIM_LIMIT_LSB : trim_sum; // RL14
  // Parabolic temperature trim
  assign gain = {st.crystal_gain_high[6:0], st.crystal_gain_low};
  assign temp_diff = $signed({1'b0, temperature_reading}) -
                     $signed({1'b0, st.crystal_turnover_offset});
  assign temp_sq = 18'(temp_diff * temp_diff);
  assign temp_prod = 33'(gain) * 33'(temp_sq);
  assign temp_corr = 18'(temp_prod >> GAIN_SHIFT); // RL19
  assign wr_hit = sfr_wr;

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    // Trim window: reload pulse budget every window
    if (xtal_tick) begin
      next_st.win = (st.win == 19'(TRIM_WINDOW_TICKS - 1)) ? 19'h00000 : st.win + 19'h00001;
      if (st.win == 19'(TRIM_WINDOW_TICKS - 1)) begin
        next_st.trim_left = 8'(trim_sat < 0 ? -trim_sat : trim_sat);
        next_st.trim_add = (trim_sat > 0);
      end
    end
    if (st.ins_pend && !xtal_tick) begin
      next_st.ins_pend = 1'b0;
    end
    if (st.skip_pend && xtal_tick) begin
      next_st.skip_pend = 1'b0;
    end
    if (st.trim_left != 8'h00 && !st.ins_pend && !st.skip_pend && !xtal_tick) begin
      next_st.trim_left = st.trim_left - 8'h01;
      next_st.ins_pend = st.trim_add; // RL13
      next_st.skip_pend = !st.trim_add;
    end
    // Prescalers
    if (ctick) begin
      next_st.presc = sec_tick ? 16'h0000 : st.presc + 16'h0001;
      next_st.div128 = st.div128 + 8'h01;
    end
    // Calendar
    if (sec_tick) begin
      next_st.sec = min_tick ? 6'h00 : st.sec + 6'h01;
      if (min_tick) begin
        next_st.min = hour_tick ? 6'h00 : st.min + 6'h01;
      end
      if (hour_tick) begin
        next_st.hour = (st.hour == LAST_HOUR) ? 5'h00 : st.hour + 5'h01;
        if (st.hour == LAST_HOUR) begin
          next_st.wday = (st.wday == LAST_WEEKDAY) ? 3'h0 : st.wday + 3'h1;
          if (st.date >= rtcc_month_days(st.month, st.year)) begin
            next_st.date = FIRST_DAY; // RL23
            next_st.month = (st.month >= LAST_MONTH) ? FIRST_MONTH : st.month + 4'h1;
            if (st.month >= LAST_MONTH) begin
              next_st.year = (st.year == LAST_YEAR) ? 7'h00 : st.year + 7'h01; // RL23
            end
          end else begin
            next_st.date = st.date + 5'h01;
          end
        end
      end
    end
    // Interval settings cross into the 128 Hz domain
    if (t128) begin
      next_st.it_en_s = st.rtc_config[CFG_INTERVAL_RUN_ENABLE]; // RL24
      next_st.it_src_s = st.rtc_config[CFG_TICK_SOURCE_HI:CFG_TICK_SOURCE_LO];
      next_st.it_one_shot_s = st.rtc_config[CFG_INTERVAL_ONE_SHOT];
      next_st.it_limit_s = st.interval_limit;
    end
    // Interval counter
    if (!st.it_en_s) begin
      next_st.it_cnt = 8'h00;
      next_st.it_hold = 1'b0;
    end else if (src_tick && !st.it_hold) begin
      if (st.it_cnt == st.it_limit_s) begin
        next_st.it_cnt = 8'h00; // RL8
        next_st.it_hold = st.it_one_shot_s; // RL8
      end else begin
        next_st.it_cnt = st.it_cnt + 8'h01; // RL7
      end
    end
    next_st.alarm_prev = alarm_match;
    // Register writes; flags clear on a written zero
    if (wr_hit) begin
      unique case (sfr_addr)
        ADDR_RTC_CONFIG: begin
          next_st.rtc_config = sfr_wdata;
          next_st.interval_match_flag = st.interval_match_flag &&
                                        sfr_wdata[CFG_INTERVAL_MATCH_FLAG]; // RL4
        end
        ADDR_ALARM_CONFIG: begin
          next_st.alarm_en = sfr_wdata[ALM_EN_MONTHDAY:ALM_EN_SECOND];
          next_st.alarm_match_flag = st.alarm_match_flag && sfr_wdata[ALM_MATCH_FLAG]; // RL4
        end
        ADDR_CAL_OUTPUT_CONFIG: next_st.cal_output_config = sfr_wdata;
        ADDR_NOMINAL_CLOCK_TRIM: next_st.nominal_clock_trim = sfr_wdata;
        ADDR_TEMPERATURE_CORRECTION: begin
          if (!st.crystal_gain_high[GAIN_AUTO_ENABLE]) begin
            next_st.temperature_correction = sfr_wdata; // RL21
          end
        end
        ADDR_CRYSTAL_TURNOVER_OFFSET: next_st.crystal_turnover_offset = sfr_wdata;
        ADDR_CRYSTAL_GAIN_LOW: next_st.crystal_gain_low = sfr_wdata;
        ADDR_CRYSTAL_GAIN_HIGH: next_st.crystal_gain_high = sfr_wdata; // RL20
        ADDR_SECOND: next_st.sec = sfr_wdata[5:0];
        ADDR_MINUTE: next_st.min = sfr_wdata[5:0];
        ADDR_HOUR: next_st.hour = sfr_wdata[4:0];
        ADDR_WEEKDAY: next_st.wday = sfr_wdata[2:0];
        ADDR_MONTHDAY: next_st.date = sfr_wdata[4:0];
        ADDR_MONTH: next_st.month = sfr_wdata[3:0];
        ADDR_YEAR: next_st.year = sfr_wdata[6:0];
        ADDR_ALARM_SECOND: next_st.alarm_second_field = sfr_wdata[5:0];
        ADDR_ALARM_MINUTE: next_st.alarm_minute_field = sfr_wdata[5:0];
        ADDR_ALARM_HOUR: next_st.alarm_hour_field = sfr_wdata[4:0];
        ADDR_ALARM_WEEKDAY: next_st.alarm_weekday_field = sfr_wdata[2:0];
        ADDR_ALARM_MONTHDAY: next_st.alarm_monthday_field = sfr_wdata[4:0];
        ADDR_INTERVAL_LIMIT: next_st.interval_limit = sfr_wdata;
        default: ;
      endcase
    end
    // Events set after the write so a set wins over a clear
    if (st.it_en_s && src_tick && !st.it_hold && st.it_cnt == st.it_limit_s) begin
      next_st.interval_match_flag = 1'b1; // RL3 RL7
    end
    if (alarm_match && !st.alarm_prev) begin
      next_st.alarm_match_flag = 1'b1; // RL3 RL11
    end
    // Automatic temperature trim on each completed reading
    if (st.crystal_gain_high[GAIN_AUTO_ENABLE] && temperature_done) begin
      next_st.temperature_correction = (temp_corr > 18'(TRIM_LIMIT_LSB)) ?
        8'(TRIM_LIMIT_LSB) : temp_corr[7:0]; // RL22 RL19
    end
    // Calibration pulse generator
    if (ctick) begin
      if (st.cal_div >= rtcc_cal_half(st.cal_output_config[CAL_RATE_HI:CAL_RATE_LO]) - 16'h0001)
      begin
        next_st.cal_div = 16'h0000;
        next_st.cal_lvl = !st.cal_lvl; // RL16
      end else begin
        next_st.cal_div = st.cal_div + 16'h0001;
      end
    end
    // Read data
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_RTC_CONFIG: begin
          next_st.rdata = st.rtc_config;
          next_st.rdata[CFG_INTERVAL_RUN_ENABLE] = st.it_en_s; // effective enable
          next_st.rdata[CFG_INTERVAL_MATCH_FLAG] = st.interval_match_flag;
        end
        ADDR_ALARM_CONFIG: next_st.rdata = {1'b0, st.alarm_match_flag, 1'b0, st.alarm_en}; // RL12
        ADDR_CAL_OUTPUT_CONFIG: next_st.rdata = st.cal_output_config;
        ADDR_NOMINAL_CLOCK_TRIM: next_st.rdata = st.nominal_clock_trim;
        ADDR_TEMPERATURE_CORRECTION: next_st.rdata = st.temperature_correction;
        ADDR_CRYSTAL_TURNOVER_OFFSET: next_st.rdata = st.crystal_turnover_offset;
        ADDR_CRYSTAL_GAIN_LOW: next_st.rdata = st.crystal_gain_low;
        ADDR_CRYSTAL_GAIN_HIGH: next_st.rdata = st.crystal_gain_high;
        ADDR_SECOND: next_st.rdata = {2'h0, st.sec};
        ADDR_MINUTE: next_st.rdata = {2'h0, st.min};
        ADDR_HOUR: next_st.rdata = {3'h0, st.hour};
        ADDR_WEEKDAY: next_st.rdata = {5'h00, st.wday};
        ADDR_MONTHDAY: next_st.rdata = {3'h0, st.date};
        ADDR_MONTH: next_st.rdata = {4'h0, st.month};
        ADDR_YEAR: next_st.rdata = {1'b0, st.year};
        ADDR_ALARM_SECOND: next_st.rdata = {2'h0, st.alarm_second_field};
        ADDR_ALARM_MINUTE: next_st.rdata = {2'h0, st.alarm_minute_field};
        ADDR_ALARM_HOUR: next_st.rdata = {3'h0, st.alarm_hour_field};
        ADDR_ALARM_WEEKDAY: next_st.rdata = {5'h00, st.alarm_weekday_field};
        ADDR_ALARM_MONTHDAY: next_st.rdata = {3'h0, st.alarm_monthday_field};
        ADDR_INTERVAL_LIMIT: next_st.rdata = st.interval_limit;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; calendar starts at the first day of the first month
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.date <= FIRST_DAY;
      st.month <= FIRST_MONTH;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sfr_rdata = st.rdata;
  assign clock_irq_pending = st.alarm_match_flag || st.interval_match_flag; // RL5
  assign clock_irq = clock_irq_pending && clock_irq_enable; // RL3
  // Keeps waking until software clears the flag
  assign wake_request = clock_irq_pending; // RL6
  genvar gi;
  generate
    for (gi = 0; gi < CAL_PIN_COUNT; gi++) begin : g_cal
      assign cal_out[gi] = st.cal_output_config[CAL_OUTPUT_ENABLE] &&
                           st.cal_output_config[gi] && st.cal_lvl; // RL15
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_day_end;
    hour_tick && st.hour == LAST_HOUR;
  endsequence
  feb_rollover_a: assert property ( // RL2
    s_day_end and (st.month == MONTH_FEB && st.date == DAYS_LEAP_FEB &&
    st.year[1:0] == 2'h0 && !wr_hit) |=> st.date == FIRST_DAY)
    else $error("leap February did not roll after day 29");
  short_month_a: assert property ( // RL1
    s_day_end and (st.month == MONTH_APR && st.date == DAYS_SHORT && !wr_hit)
    |=> st.date == FIRST_DAY && st.month == 4'h5)
    else $error("thirty-day month did not roll");
  irq_gate_a: assert property ( // RL3
    clock_irq == (clock_irq_enable && (st.alarm_match_flag || st.interval_match_flag)))
    else $error("interrupt not gated by enable");
  flag_sticky_a: assert property ( // RL4
    st.interval_match_flag && !(wr_hit && sfr_addr == ADDR_RTC_CONFIG)
    |=> st.interval_match_flag)
    else $error("interval flag cleared without a write");
  pending_hold_a: assert property (clock_irq_pending && !wr_hit |=> clock_irq_pending [*1]) // RL6
    else $error("pending request dropped without software clear");
  interval_hit_a: assert property ( // RL7
    st.it_en_s && src_tick && !st.it_hold && st.it_cnt == st.it_limit_s
    |=> st.interval_match_flag && st.it_cnt == 8'h00)
    else $error("interval event not flagged at limit");
  one_shot_a: assert property (st.it_hold && st.it_en_s |=> st.it_cnt == 8'h00) // RL8
    else $error("one-shot counter not held");
  tcal_lock_a: assert property ( // RL21
    st.crystal_gain_high[GAIN_AUTO_ENABLE] && !temperature_done
    |=> st.temperature_correction == $past(st.temperature_correction))
    else $error("temperature correction changed while locked");
  trim_cap_a: assert property ( // RL14
    xtal_tick && st.win == 19'(TRIM_WINDOW_TICKS - 1) |=> st.trim_left <= 8'(TRIM_LIMIT_LSB))
    else $error("trim budget above limit");
  cal_off_a: assert property (!st.cal_output_config[CAL_OUTPUT_ENABLE] |-> cal_out == '0) // RL15
    else $error("calibration output active while disabled");
endmodule

// file: sim/tb_top.sv
// Bench for the clock block: calendar, alarm, interval, trim lock, pulse output.
// Assumes rtcc_pkg and rtcc_top are compiled first; one 100 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcc_pkg::*;
  logic mclk = 0, rst_n = 0, xtal_tick = 0, sfr_wr = 0, sfr_rd = 0, irq_en = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, q;
  logic pend, irq, wake;
  logic [1:0] pm = 2'h0;
  logic [7:0] temp_rd = 8'h00;
  logic temp_done = 1'b0;
  logic [3:0] cal_out, seen;
  int err_total = 0, check_count = 0, cyc = 0;
  // Short second and trim window keep the run small
  rtcc_top #(.SECOND_TICKS(8), .TRIM_WINDOW_TICKS(64)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .xtal_tick(xtal_tick), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .clock_irq_enable(irq_en),
    .power_mode(pm), .temperature_reading(temp_rd), .temperature_done(temp_done),
    .clock_irq_pending(pend), .clock_irq(irq), .wake_request(wake), .cal_out(cal_out));
  always #5 mclk = ~mclk;
  // Crystal pulse every fourth cycle; idle gaps allow pulse insertion
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    xtal_tick <= #1 (cyc % 4 == 0);
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk) #1 sfr_wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk) #1 sfr_rd = 1'b0;
    @(posedge mclk) #1 q = sfr_rdata;
  endtask
  task automatic wait_pend(input int n);
    for (int i = 0; i < n && pend !== 1'b1; i++) @(posedge mclk) #1;
    #1 chk({7'h0, pend}, 8'h01);
  endtask
  // Seconds written last so the day rollover lands after the date is set
  task automatic cal(input logic [7:0] y, m, d, ey, em, ed);
    wr(ADDR_YEAR, y);
    wr(ADDR_MONTH, m);
    wr(ADDR_MONTHDAY, d);
    wr(ADDR_HOUR, 8'h17);
    wr(ADDR_MINUTE, 8'h3B);
    wr(ADDR_SECOND, 8'h3B);
    repeat (120) @(posedge mclk);
    rd(ADDR_MONTHDAY);
    chk(q, ed);
    rd(ADDR_MONTH);
    chk(q, em);
    rd(ADDR_YEAR);
    chk(q, ey);
    $display("calendar case done");
  endtask
  task automatic t_alarm();
    wr(ADDR_ALARM_SECOND, 8'h05);
    wr(ADDR_ALARM_CONFIG, 8'h01);
    wait_pend(3000);
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_ALARM_CONFIG);
    chk(q, 8'h41);
    irq_en = 1'b1;
    #1 chk({6'h0, irq, wake}, 8'h03);
    wr(ADDR_ALARM_CONFIG, 8'h00);
    #1 chk({7'h0, pend}, 8'h00);
    $display("alarm test done");
  endtask
  // One-shot interval at the 128 Hz source with limit zero
  // Then a timebase change to seconds, following the safe disable sequence
  task automatic t_interval();
    wr(ADDR_INTERVAL_LIMIT, 8'h00);
    repeat (1100) @(posedge mclk);
    wr(ADDR_RTC_CONFIG, 8'h48);
    wait_pend(4000);
    rd(ADDR_RTC_CONFIG);
    chk(q, 8'h4C);
    wr(ADDR_RTC_CONFIG, 8'h48);
    repeat (2500) @(posedge mclk);
    chk({7'h0, pend}, 8'h00);
    wr(ADDR_RTC_CONFIG, 8'h00);
    repeat (1100) @(posedge mclk);
    rd(ADDR_RTC_CONFIG);
    chk(q, 8'h00);
    wr(ADDR_RTC_CONFIG, 8'h10);
    repeat (1100) @(posedge mclk);
    wr(ADDR_RTC_CONFIG, 8'h50);
    wait_pend(2200);
    rd(ADDR_RTC_CONFIG);
    chk(q, 8'h54);
    wr(ADDR_RTC_CONFIG, 8'h10);
    $display("interval test done");
  endtask
  // One completed temperature reading, held for a single cycle
  task automatic pulse_temp(input logic [7:0] r);
    temp_rd = r;
    temp_done = 1'b1;
    @(posedge mclk) #1 temp_done = 1'b0;
  endtask
  // Gain 0x4000 over 2^15: an offset of 4 gives 8, a large offset saturates
  task automatic t_trim();
    rd(ADDR_CRYSTAL_GAIN_HIGH);
    chk(q, 8'h00);
    wr(ADDR_CRYSTAL_TURNOVER_OFFSET, 8'h10);
    wr(ADDR_CRYSTAL_GAIN_HIGH, 8'hC0);
    pulse_temp(8'h14);
    rd(ADDR_TEMPERATURE_CORRECTION);
    chk(q, 8'h08);
    wr(ADDR_TEMPERATURE_CORRECTION, 8'h11);
    rd(ADDR_TEMPERATURE_CORRECTION);
    chk(q, 8'h08);
    pulse_temp(8'hFF);
    rd(ADDR_TEMPERATURE_CORRECTION);
    chk(q, 8'h7C);
    wr(ADDR_CRYSTAL_GAIN_HIGH, 8'h00);
    wr(ADDR_TEMPERATURE_CORRECTION, 8'h11);
    rd(ADDR_TEMPERATURE_CORRECTION);
    chk(q, 8'h11);
    wr(ADDR_TEMPERATURE_CORRECTION, 8'h00);
    $display("trim test done");
  endtask
  // Fast rate: a sped-up second is far longer than the short bench second
  task automatic t_fast(input logic [1:0] m, input logic [7:0] exp);
    pm = m;
    wr(ADDR_CAL_OUTPUT_CONFIG, 8'h30);
    wr(ADDR_SECOND, 8'h00);
    repeat (100) @(posedge mclk);
    rd(ADDR_SECOND);
    chk({7'h0, q != 8'h00}, exp);
    $display("fast mode case done");
  endtask
  // Fastest rate so the pins toggle within a few crystal pulses
  task automatic t_calout(input logic [7:0] v, input logic [3:0] exp);
    wr(ADDR_CAL_OUTPUT_CONFIG, v);
    seen = 4'h0;
    repeat (60) @(posedge mclk) seen = seen | cal_out;
    chk({4'h0, seen}, {4'h0, exp});
    $display("pulse output case done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(8'h30);
    chk(q, 8'h00);
    rd(ADDR_ALARM_CONFIG);
    chk(q, 8'h00);
    cal(8'h04, 8'h02, 8'h1C, 8'h04, 8'h02, 8'h1D);
    cal(8'h04, 8'h02, 8'h1D, 8'h04, 8'h03, 8'h01);
    cal(8'h05, 8'h02, 8'h1C, 8'h05, 8'h03, 8'h01);
    cal(8'h05, 8'h04, 8'h1E, 8'h05, 8'h05, 8'h01);
    cal(8'h07, 8'h0C, 8'h1F, 8'h08, 8'h01, 8'h01);
    t_alarm();
    t_interval();
    t_trim();
    t_fast(2'h2, 8'h01);
    t_fast(2'h0, 8'h00);
    t_calout(8'h35, 4'h0);
    t_calout(8'h75, 4'h5);
    give_verdict();
  end
endmodule
